// [hdl/bscan_pkg.sv]
`default_nettype none

package bscan_pkg;

	// ------------------------------------------------------------------
	// Chain geometry
	// ------------------------------------------------------------------
	localparam int IO_PINS      = 64;
	localparam int DED_PINS     = 4;
	localparam int MC_CELLS     = 64;
	localparam int IO_CELL_BITS = 3;
	localparam int DED_BASE     = 0;
	localparam int IO_BASE      = DED_BASE + DED_PINS;
	localparam int MC_BASE      = IO_BASE + IO_PINS * IO_CELL_BITS;
	localparam int CHAIN_LEN    = MC_BASE + MC_CELLS;
	// Positions of the three capture stages inside one pin cell
	localparam int IO_IN_POS    = 0;
	localparam int IO_OUT_POS   = 1;
	localparam int IO_OE_POS    = 2;

	// ------------------------------------------------------------------
	// Instructions
	// ------------------------------------------------------------------
	localparam int IR_LEN = 4;
	typedef logic [IR_LEN-1:0] instr_t;
	localparam instr_t INSTR_EXTEST = 4'h0;
	localparam instr_t INSTR_SAMPLE = 4'h1;
	localparam instr_t INSTR_IDCODE = 4'h2;
	localparam instr_t INSTR_HIGHZ  = 4'h3;
	localparam instr_t INSTR_BYPASS = 4'hf;
	localparam instr_t IR_CAPTURE   = 4'h1;
	localparam instr_t IR_RESET     = INSTR_IDCODE;

	// Identification register; the value is arbitrary, bit 0 must be one
	localparam int          ID_LEN         = 32;
	localparam logic [31:0] IDCODE_DEFAULT = 32'h0000_0001;

	// ------------------------------------------------------------------
	// Monitor stream
	// ------------------------------------------------------------------
	localparam int         MON_WIDTH    = 8;
	localparam int         MON_DEPTH    = 16;
	localparam logic [2:0] MON_CNT_LAST = 3'h7;
	localparam logic [2:0] MON_CNT_RST  = 3'h0;

	// ------------------------------------------------------------------
	// Controller states, one-hot
	// ------------------------------------------------------------------
	typedef enum logic [15:0] {
		ST_RESET  = 16'h0001, ST_IDLE   = 16'h0002,
		ST_SEL_DR = 16'h0004, ST_CAP_DR = 16'h0008,
		ST_SH_DR  = 16'h0010, ST_EX1_DR = 16'h0020,
		ST_PA_DR  = 16'h0040, ST_EX2_DR = 16'h0080,
		ST_UPD_DR = 16'h0100, ST_SEL_IR = 16'h0200,
		ST_CAP_IR = 16'h0400, ST_SH_IR  = 16'h0800,
		ST_EX1_IR = 16'h1000, ST_PA_IR  = 16'h2000,
		ST_EX2_IR = 16'h4000, ST_UPD_IR = 16'h8000
	} tap_state_t;

endpackage : bscan_pkg

`default_nettype wire

// [hdl/boundary_scan_test_port.sv]
`default_nettype none


// ----------------------------------------------------------------------
// Dual-clock word FIFO, gray pointers
// ----------------------------------------------------------------------
module mon_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	// Fill side
	input  wire logic             wr_clk_i,
	input  wire logic             wr_rst_i,
	input  wire logic             wr_valid_i,
	input  wire logic [WIDTH-1:0] wr_data_i,
	output logic                  wr_ready_o,
	// Drain side
	input  wire logic             rd_clk_i,
	input  wire logic             rd_rst_i,
	input  wire logic             rd_ready_i,
	output logic                  rd_valid_o,
	output logic      [WIDTH-1:0] rd_data_o
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wbin_r;
	logic [AW:0]      wgray_r;
	logic [AW:0]      rbin_r;
	logic [AW:0]      rgray_r;
	logic [AW:0]      rg_m_r;
	logic [AW:0]      rg_s_r;
	logic [AW:0]      wg_m_r;
	logic [AW:0]      wg_s_r;
	logic [AW:0]      wbin_nxt;
	logic [AW:0]      rbin_nxt;
	logic             push;
	logic             load;
	logic             full;
	logic             empty;

	function automatic logic [AW:0] to_gray(input logic [AW:0] b);
		to_gray = b ^ (b >> 1);
	endfunction : to_gray

	// Full compares against the synchronised read pointer, so it is
	// pessimistic by a few cycles but never overwrites
	assign full       = wgray_r == {~rg_s_r[AW:AW-1], rg_s_r[AW-2:0]};
	assign empty      = rgray_r == wg_s_r;
	assign wr_ready_o = ~full;
	assign push       = wr_valid_i & ~full;
	assign load       = ~empty & (~rd_valid_o | rd_ready_i);
	assign wbin_nxt   = wbin_r + {{AW{1'b0}}, push};
	assign rbin_nxt   = rbin_r + {{AW{1'b0}}, load};

	// Storage write
	always_ff @(posedge wr_clk_i) begin
		if (push)
			mem[wbin_r[AW-1:0]] <= wr_data_i;
	end

	// Write pointer and read pointer crossing
	always_ff @(posedge wr_clk_i) begin
		if (wr_rst_i) begin
			wbin_r  <= '0;
			wgray_r <= '0;
			rg_m_r  <= '0;
			rg_s_r  <= '0;
		end else begin
			wbin_r  <= wbin_nxt;
			wgray_r <= to_gray(wbin_nxt);
			rg_m_r  <= rgray_r;
			rg_s_r  <= rg_m_r;
		end
	end

	// Read pointer, registered output, write pointer crossing
	always_ff @(posedge rd_clk_i) begin
		if (rd_rst_i) begin
			rbin_r     <= '0;
			rgray_r    <= '0;
			wg_m_r     <= '0;
			wg_s_r     <= '0;
			rd_valid_o <= 1'b0;
			rd_data_o  <= '0;
		end else begin
			rbin_r  <= rbin_nxt;
			rgray_r <= to_gray(rbin_nxt);
			wg_m_r  <= wgray_r;
			wg_s_r  <= wg_m_r;
			if (load) begin
				rd_valid_o <= 1'b1;
				rd_data_o  <= mem[rbin_r[AW-1:0]];
			end else if (rd_ready_i) begin
				rd_valid_o <= 1'b0;
			end
		end
	end

endmodule : mon_fifo

// ----------------------------------------------------------------------
// Boundary-scan test port
// ----------------------------------------------------------------------
module boundary_scan_test_port
	import bscan_pkg::*;
#(
	parameter logic [31:0] IDCODE = IDCODE_DEFAULT
) (
	// Clock and reset
	input  wire logic                 clk_i,
	input  wire logic                 reset_i,
	// Configuration straps
	input  wire logic                 jtag_en_i,
	input  wire logic                 pullup_tms_sel_i,
	input  wire logic                 pullup_tdi_sel_i,
	// Test pins
	input  wire logic                 tck_i,
	input  wire logic                 tms_i,
	input  wire logic                 tdi_i,
	output logic                      tdo_o,
	output logic                      tdo_oe_o,
	output logic                      pullup_tms_en_o,
	output logic                      pullup_tdi_en_o,
	// Test pins in their user role
	input  wire logic                 user_tdo_i,
	input  wire logic                 user_tdo_oe_i,
	output logic                      user_tdo_o,
	output logic                      user_tdo_oe_o,
	output logic [2:0]                user_pin_in_o,
	// Device pins
	input  wire logic [IO_PINS-1:0]   pad_in_i,
	input  wire logic [DED_PINS-1:0]  ded_in_i,
	output logic      [IO_PINS-1:0]   pad_out_o,
	output logic      [IO_PINS-1:0]   pad_oe_o,
	// Core logic
	input  wire logic [IO_PINS-1:0]   core_out_i,
	input  wire logic [IO_PINS-1:0]   core_oe_i,
	input  wire logic [MC_CELLS-1:0]  mc_state_i,
	output logic      [IO_PINS-1:0]   core_pad_in_o,
	output logic      [DED_PINS-1:0]  core_ded_in_o,
	// Monitor stream of scanned-out data
	input  wire logic                 mon_ready_i,
	output logic                      mon_valid_o,
	output logic      [MON_WIDTH-1:0] mon_data_o,
	output logic                      mon_overrun_o
);

	// ------------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------------
	tap_state_t           tap_r;
	tap_state_t           tap_nxt;
	instr_t               instr_r;
	instr_t               ir_sh_r;
	logic [CHAIN_LEN-1:0] cap_raw;
	logic [CHAIN_LEN-1:0] cap_m_r;
	logic [CHAIN_LEN-1:0] cap_s_r;
	logic [CHAIN_LEN-1:0] bsr_r;
	logic [ID_LEN-1:0]    id_r;
	logic                 byp_r;
	logic [IO_PINS-1:0]   upd_out_r;
	logic [IO_PINS-1:0]   upd_oe_r;
	logic [IO_PINS-1:0]   bsr_out_f;
	logic [IO_PINS-1:0]   bsr_oe_f;
	logic                 hold_r;
	logic                 hold_m_r;
	logic                 tap_rst;
	logic                 rst_seen_r;
	logic                 ack_m_r;
	logic                 ack_s_r;
	logic                 fifo_rd_rst;
	logic [2:0]           en_m_r;
	logic [2:0]           en_s_r;
	logic                 sel_bsr;
	logic                 sel_id;
	logic                 dr_out;
	logic                 in_sh_dr;
	logic                 in_sh_ir;
	logic                 mode_extest;
	logic                 mode_highz;
	logic [IO_PINS*2+1:0] xm_m_r;
	logic [IO_PINS*2+1:0] xm_s_r;
	logic [IO_PINS-1:0]   pin_m_r;
	logic [DED_PINS-1:0]  ded_m_r;
	logic [2:0]           upin_m_r;
	logic [2:0]           upin_s_r;
	logic [MON_WIDTH-1:0] pk_r;
	logic [MON_WIDTH-1:0] pk_byte;
	logic [2:0]           pk_cnt_r;
	logic [MON_WIDTH-1:0] pend_data_r;
	logic                 pend_r;
	logic                 byte_done;
	logic                 fifo_ready;
	logic                 push;
	logic                 ovr_r;
	logic                 ovr_m_r;
	logic                 ovr_s_r;

	// ------------------------------------------------------------------
	// Controller reset, no reset pin on the port
	// ------------------------------------------------------------------
	// Power-up reset or a disabled port holds the controller in reset;
	// it reaches the TCK side as a level through two flops. TCK may be
	// stopped, so the hold stays up until the TCK side reports back
	always_ff @(posedge clk_i) begin
		if (reset_i || !en_s_r[0])
			hold_r <= 1'b1;
		else if (ack_s_r)
			hold_r <= 1'b0;
	end

	always_ff @(posedge tck_i) begin
		hold_m_r   <= hold_r;
		tap_rst    <= hold_m_r;
		rst_seen_r <= tap_rst;
	end

	// FIFO read side stays in reset until the write side has cleared
	assign fifo_rd_rst = reset_i | hold_r;

	// ------------------------------------------------------------------
	// Controller state machine
	// ------------------------------------------------------------------
	always_comb begin
		tap_nxt = tap_r;
		case (tap_r)
			ST_RESET:  tap_nxt = tms_i ? ST_RESET  : ST_IDLE;
			ST_IDLE:   tap_nxt = tms_i ? ST_SEL_DR : ST_IDLE;
			ST_SEL_DR: tap_nxt = tms_i ? ST_SEL_IR : ST_CAP_DR;
			ST_CAP_DR: tap_nxt = tms_i ? ST_EX1_DR : ST_SH_DR;
			ST_SH_DR:  tap_nxt = tms_i ? ST_EX1_DR : ST_SH_DR;
			ST_EX1_DR: tap_nxt = tms_i ? ST_UPD_DR : ST_PA_DR;
			ST_PA_DR:  tap_nxt = tms_i ? ST_EX2_DR : ST_PA_DR;
			ST_EX2_DR: tap_nxt = tms_i ? ST_UPD_DR : ST_SH_DR;
			ST_UPD_DR: tap_nxt = tms_i ? ST_SEL_DR : ST_IDLE;
			ST_SEL_IR: tap_nxt = tms_i ? ST_RESET  : ST_CAP_IR;
			ST_CAP_IR: tap_nxt = tms_i ? ST_EX1_IR : ST_SH_IR;
			ST_SH_IR:  tap_nxt = tms_i ? ST_EX1_IR : ST_SH_IR;
			ST_EX1_IR: tap_nxt = tms_i ? ST_UPD_IR : ST_PA_IR;
			ST_PA_IR:  tap_nxt = tms_i ? ST_EX2_IR : ST_PA_IR;
			ST_EX2_IR: tap_nxt = tms_i ? ST_UPD_IR : ST_SH_IR;
			ST_UPD_IR: tap_nxt = tms_i ? ST_SEL_DR : ST_IDLE;
			default:   tap_nxt = ST_RESET;
		endcase
	end

	always_ff @(posedge tck_i) begin
		if (tap_rst)
			tap_r <= ST_RESET;
		else
			tap_r <= tap_nxt;
	end

	// ------------------------------------------------------------------
	// Instruction register and decode
	// ------------------------------------------------------------------
	always_ff @(posedge tck_i) begin
		if (tap_rst || tap_r == ST_RESET) begin
			ir_sh_r <= IR_CAPTURE;
			instr_r <= IR_RESET;
		end else if (tap_r == ST_CAP_IR) begin
			ir_sh_r <= IR_CAPTURE;
		end else if (tap_r == ST_SH_IR) begin
			ir_sh_r <= {tdi_i, ir_sh_r[IR_LEN-1:1]};
		end else if (tap_r == ST_UPD_IR) begin
			instr_r <= ir_sh_r;
		end
	end

	// Unknown codes fall back to bypass, so only five behaviours exist
	assign sel_bsr     = instr_r == INSTR_EXTEST ||
	                     instr_r == INSTR_SAMPLE;
	assign sel_id      = instr_r == INSTR_IDCODE;
	assign mode_extest = instr_r == INSTR_EXTEST;
	assign mode_highz  = instr_r == INSTR_HIGHZ;
	assign in_sh_dr    = tap_r == ST_SH_DR;
	assign in_sh_ir    = tap_r == ST_SH_IR;
	assign dr_out      = sel_bsr ? bsr_r[0] :
	                     sel_id  ? id_r[0]  : byp_r;

	// ------------------------------------------------------------------
	// Capture sources, chain indexed from TDO (bit 0) towards TDI
	// ------------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < IO_PINS; gi++) begin : g_io
			// Pin cell: input, output and enable captures
			assign cap_raw[IO_BASE+gi*IO_CELL_BITS+IO_IN_POS]  =
				pad_in_i[gi];
			assign cap_raw[IO_BASE+gi*IO_CELL_BITS+IO_OUT_POS] =
				core_out_i[gi];
			assign cap_raw[IO_BASE+gi*IO_CELL_BITS+IO_OE_POS]  =
				core_oe_i[gi];
			assign bsr_out_f[gi] = bsr_r[IO_BASE+gi*IO_CELL_BITS+IO_OUT_POS];
			assign bsr_oe_f[gi]  = bsr_r[IO_BASE+gi*IO_CELL_BITS+IO_OE_POS];
		end
		for (gi = 0; gi < DED_PINS; gi++) begin : g_ded
			assign cap_raw[DED_BASE+gi] = ded_in_i[gi];
		end
		for (gi = 0; gi < MC_CELLS; gi++) begin : g_mc
			// Macrocell cell: capture only, no update stage
			assign cap_raw[MC_BASE+gi] = mc_state_i[gi];
		end
	endgenerate

	// Captured levels come from other domains, so two flops first
	always_ff @(posedge tck_i) begin
		cap_m_r <= cap_raw;
		cap_s_r <= cap_m_r;
	end

	// ------------------------------------------------------------------
	// Data registers: boundary chain, identification, bypass
	// ------------------------------------------------------------------
	always_ff @(posedge tck_i) begin
		if (tap_rst)
			bsr_r <= '0;
		else if (sel_bsr && tap_r == ST_CAP_DR)
			bsr_r <= cap_s_r;
		else if (sel_bsr && in_sh_dr)
			bsr_r <= {tdi_i, bsr_r[CHAIN_LEN-1:1]};
	end

	always_ff @(posedge tck_i) begin
		if (tap_rst) begin
			id_r  <= '0;
			byp_r <= 1'b0;
		end else if (tap_r == ST_CAP_DR) begin
			id_r  <= IDCODE;
			byp_r <= 1'b0;
		end else if (in_sh_dr) begin
			id_r  <= {tdi_i, id_r[ID_LEN-1:1]};
			byp_r <= tdi_i;
		end
	end

	// Update stages, loaded only from the boundary chain
	always_ff @(posedge tck_i) begin
		if (tap_rst) begin
			upd_out_r <= '0;
			upd_oe_r  <= '0;
		end else if (sel_bsr && tap_r == ST_UPD_DR) begin
			upd_out_r <= bsr_out_f;
			upd_oe_r  <= bsr_oe_f;
		end
	end

	// ------------------------------------------------------------------
	// Serial output on the falling edge
	// ------------------------------------------------------------------
	always_ff @(negedge tck_i) begin
		if (tap_rst) begin
			tdo_o    <= 1'b0;
			tdo_oe_o <= 1'b0;
		end else begin
			tdo_o    <= in_sh_ir ? ir_sh_r[0] : dr_out;
			tdo_oe_o <= in_sh_ir | in_sh_dr;
		end
	end

	// ------------------------------------------------------------------
	// Monitor packer, TCK side
	// ------------------------------------------------------------------
	// Bytes are counted from each capture; a trailing part byte is lost
	assign pk_byte   = {dr_out, pk_r[MON_WIDTH-1:1]};
	assign byte_done = in_sh_dr && pk_cnt_r == MON_CNT_LAST;
	assign push      = pend_r & fifo_ready;

	always_ff @(posedge tck_i) begin
		if (tap_rst || tap_r == ST_CAP_DR) begin
			pk_r     <= '0;
			pk_cnt_r <= MON_CNT_RST;
		end else if (in_sh_dr) begin
			pk_r     <= pk_byte;
			pk_cnt_r <= pk_cnt_r + 3'h1;
		end
	end

	// TCK cannot be stalled, so a full FIFO holds one pending byte and
	// flags an overrun when a further byte arrives before it drains
	always_ff @(posedge tck_i) begin
		if (tap_rst) begin
			pend_r      <= 1'b0;
			pend_data_r <= '0;
			ovr_r       <= 1'b0;
		end else begin
			if (byte_done && (!pend_r || push)) begin
				pend_r      <= 1'b1;
				pend_data_r <= pk_byte;
			end else if (push) begin
				pend_r <= 1'b0;
			end
			if (byte_done && pend_r && !push)
				ovr_r <= 1'b1;
		end
	end

	mon_fifo #(
		.WIDTH (MON_WIDTH),
		.DEPTH (MON_DEPTH)
	) u_fifo (
		.wr_clk_i   (tck_i),
		.wr_rst_i   (tap_rst),
		.wr_valid_i (pend_r),
		.wr_data_i  (pend_data_r),
		.wr_ready_o (fifo_ready),
		.rd_clk_i   (clk_i),
		.rd_rst_i   (fifo_rd_rst),
		.rd_ready_i (mon_ready_i),
		.rd_valid_o (mon_valid_o),
		.rd_data_o  (mon_data_o)
	);

	// ------------------------------------------------------------------
	// System side: straps, pins, mode crossing
	// ------------------------------------------------------------------
	// Update values and mode bits cross as levels; they may skew for a
	// cycle while the instruction changes
	always_ff @(posedge clk_i) begin
		en_m_r   <= {pullup_tdi_sel_i, pullup_tms_sel_i, jtag_en_i};
		en_s_r   <= en_m_r;
		xm_m_r   <= {mode_highz, mode_extest, upd_oe_r, upd_out_r};
		xm_s_r   <= xm_m_r;
		pin_m_r  <= pad_in_i;
		ded_m_r  <= ded_in_i;
		upin_m_r <= {tdi_i, tms_i, tck_i};
		upin_s_r <= upin_m_r;
		ovr_m_r  <= ovr_r;
		ovr_s_r  <= ovr_m_r;
		ack_m_r  <= rst_seen_r;
		ack_s_r  <= ack_m_r;
	end

	// Pad drive: extest drives from update stages, highz floats all
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			pad_out_o       <= '0;
			pad_oe_o        <= '0;
			core_pad_in_o   <= '0;
			core_ded_in_o   <= '0;
			pullup_tms_en_o <= 1'b0;
			pullup_tdi_en_o <= 1'b0;
			user_tdo_o      <= 1'b0;
			user_tdo_oe_o   <= 1'b0;
			user_pin_in_o   <= '0;
			mon_overrun_o   <= 1'b0;
		end else begin
			pad_out_o <= xm_s_r[IO_PINS*2] ? xm_s_r[IO_PINS-1:0] :
			             core_out_i;
			pad_oe_o  <= xm_s_r[IO_PINS*2+1] ? '0 :
			             xm_s_r[IO_PINS*2] ? xm_s_r[IO_PINS*2-1:IO_PINS] :
			             core_oe_i;
			core_pad_in_o   <= pin_m_r;
			core_ded_in_o   <= ded_m_r;
			pullup_tms_en_o <= en_s_r[0] & en_s_r[1];
			pullup_tdi_en_o <= en_s_r[0] & en_s_r[2];
			user_tdo_o      <= ~en_s_r[0] & user_tdo_i;
			user_tdo_oe_o   <= ~en_s_r[0] & user_tdo_oe_i;
			user_pin_in_o   <= en_s_r[0] ? 3'h0 : upin_s_r;
			mon_overrun_o   <= mon_overrun_o | ovr_s_r; // Sticky to reset
		end
	end

endmodule : boundary_scan_test_port

`default_nettype wire

// [verif/boundary_scan_test_port_sva.sv]
`default_nettype none

// ------------------------------------------------------------------
// Port checker
// ------------------------------------------------------------------
module bscan_checker
	import bscan_pkg::*;
(
	// Clock, reset and straps
	input wire logic                 clk_i,
	input wire logic                 reset_i,
	input wire logic                 jtag_en_i,
	input wire logic                 pullup_tms_sel_i,
	// Test pins
	input wire logic                 tck_i,
	input wire logic                 tdo_o,
	input wire logic                 tdo_oe_o,
	input wire logic                 pullup_tms_en_o,
	input wire logic                 user_tdo_oe_i,
	input wire logic                 user_tdo_oe_o,
	input wire logic [2:0]           user_pin_in_o,
	// Pins and core
	input wire logic [IO_PINS-1:0]   pad_in_i,
	input wire logic [IO_PINS-1:0]   core_pad_in_o,
	input wire logic [IO_PINS-1:0]   core_oe_i,
	input wire logic [IO_PINS-1:0]   pad_oe_o,
	// Monitor stream
	input wire logic                 mon_ready_i,
	input wire logic                 mon_valid_o,
	input wire logic [MON_WIDTH-1:0] mon_data_o,
	input wire logic                 mon_overrun_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (reset_i);

	// Strap held long enough to pass its synchroniser
	sequence s_off;
		!jtag_en_i [*4];
	endsequence
	sequence s_on;
		jtag_en_i [*4];
	endsequence
	// Two samples with tck high: no falling edge can lie between them
	sequence s_tck_high;
		tck_i ##1 tck_i;
	endsequence

	chk_tdo_on_fall: assert property (
		s_tck_high |-> $stable(tdo_o) && $stable(tdo_oe_o))
		else $error("tdo moved while tck was high");
	chk_user_oe_off: assert property (
		(!jtag_en_i && user_tdo_oe_i) [*4] |-> user_tdo_oe_o)
		else $error("user drive lost with port disabled");
	chk_user_pins_on: assert property (
		s_on |-> !user_tdo_oe_o && user_pin_in_o == 3'h0)
		else $error("user role active with port enabled");
	chk_pullup_on: assert property (
		(jtag_en_i && pullup_tms_sel_i) [*4] |-> pullup_tms_en_o)
		else $error("selected pull-up not enabled");
	chk_pullup_off: assert property (
		s_off |-> !pullup_tms_en_o)
		else $error("pull-up enabled with port disabled");
	chk_pin_sync: assert property (
		!$past(reset_i) && !$past(reset_i, 2)
		|-> core_pad_in_o == $past(pad_in_i, 2))
		else $error("pin input latency wrong");
	chk_off_core_oe: assert property (
		(!jtag_en_i && $stable(core_oe_i)) [*4] |-> pad_oe_o == core_oe_i)
		else $error("pads not under core control when disabled");
	chk_mon_hold: assert property (
		mon_valid_o && !mon_ready_i |=> mon_valid_o && $stable(mon_data_o))
		else $error("monitor byte dropped before taken");
	chk_overrun_sticky: assert property (
		mon_overrun_o |=> mon_overrun_o)
		else $error("overrun flag cleared without reset");
	chk_reset_clear: assert property (disable iff (1'b0)
		reset_i |=> !mon_valid_o && !mon_overrun_o && pad_oe_o == '0)
		else $error("outputs not cleared by reset");

endmodule : bscan_checker

bind boundary_scan_test_port bscan_checker chk (.clk_i, .reset_i,
	.jtag_en_i, .pullup_tms_sel_i, .tck_i, .tdo_o, .tdo_oe_o,
	.pullup_tms_en_o, .user_tdo_oe_i, .user_tdo_oe_o, .user_pin_in_o,
	.pad_in_i, .core_pad_in_o, .core_oe_i, .pad_oe_o, .mon_ready_i,
	.mon_valid_o, .mon_data_o, .mon_overrun_o);

`default_nettype wire

// [verif/jtag_host.sv]
`default_nettype none

// ------------------------------------------------------------------
// External test controller
// ------------------------------------------------------------------
module jtag_host
	import bscan_pkg::*;
(
	output logic      tck_o,
	output logic      tms_o,
	output logic      tdi_o,
	input  wire logic tdo_i
);
	timeunit 1ns;
	timeprecision 100ps;

	// Test clock rests low between frames
	initial begin
		tck_o = 1'b0;
		tms_o = 1'b1;
		tdi_o = 1'b0;
	end

	// One test clock: drive after the fall, sample tdo at the rise
	task automatic step(input logic tms, input logic tdi, output logic tdo);
		tms_o = tms;
		tdi_o = tdi;
		#32;
		tdo = tdo_i;
		tck_o = 1'b1;
		#32;
		tck_o = 1'b0;
	endtask : step

	// TMS high for n clocks, then into idle
	task automatic reset_tap(input int n);
		logic d;
		repeat (n) step(1'b1, tdi_o, d);
		step(1'b0, tdi_o, d);
	endtask : reset_tap

	// Idle, capture, shift n bits LSB first, update, idle
	task automatic scan(input logic ir, input logic [CHAIN_LEN-1:0] din,
			input int n, output logic [CHAIN_LEN-1:0] dout);
		logic d;
		dout = '0;
		step(1'b1, tdi_o, d);
		if (ir) step(1'b1, tdi_o, d);
		step(1'b0, tdi_o, d);
		step(1'b0, tdi_o, d);
		for (int i = 0; i < n; i++) begin
			step(i == n - 1, din[i], d);
			dout[i] = d;
		end
		// Released data line shows the inverse, never a stale bit
		step(1'b1, ~din[n-1], d);
		step(1'b0, ~din[n-1], d);
	endtask : scan

endmodule : jtag_host

`default_nettype wire

// [verif/boundary_scan_test_port_tb.sv]
`default_nettype none

module boundary_scan_test_port_tb
	import bscan_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	// ------------------------------------------------------------------
	// Stimulus and observed signals
	// ------------------------------------------------------------------
	logic clk_i = 1'b0, reset_i = 1'b1, jtag_en_i = 1'b1;
	logic pullup_tms_sel_i = 1'b1, pullup_tdi_sel_i = 1'b1;
	logic user_tdo_i = 1'b0, user_tdo_oe_i = 1'b0, mon_ready_i = 1'b1;
	logic [IO_PINS-1:0] pad_in_i = '0, core_out_i = '1, core_oe_i = '1;
	logic [MC_CELLS-1:0] mc_state_i = 64'h5a;
	logic [DED_PINS-1:0] ded_in_i = 4'ha;
	logic tck_i, tms_i, tdi_i, tdo_o, tdo_oe_o, pullup_tms_en_o;
	logic pullup_tdi_en_o, user_tdo_o, user_tdo_oe_o, mon_valid_o;
	logic mon_overrun_o;
	logic [2:0] user_pin_in_o;
	logic [IO_PINS-1:0] pad_out_o, pad_oe_o, core_pad_in_o;
	logic [DED_PINS-1:0] core_ded_in_o;
	logic [MON_WIDTH-1:0] mon_data_o;
	logic [MON_WIDTH-1:0] got[$];
	int mismatches = 0;
	int compares = 0;
	int cycles = 0;

	boundary_scan_test_port dut (.clk_i, .reset_i, .jtag_en_i,
		.pullup_tms_sel_i, .pullup_tdi_sel_i, .tck_i, .tms_i, .tdi_i,
		.tdo_o, .tdo_oe_o, .pullup_tms_en_o, .pullup_tdi_en_o,
		.user_tdo_i, .user_tdo_oe_i, .user_tdo_o, .user_tdo_oe_o,
		.user_pin_in_o, .pad_in_i, .ded_in_i, .pad_out_o, .pad_oe_o,
		.core_out_i, .core_oe_i, .mc_state_i, .core_pad_in_o,
		.core_ded_in_o, .mon_ready_i, .mon_valid_o, .mon_data_o,
		.mon_overrun_o);
	jtag_host host (.tck_o(tck_i), .tms_o(tms_i), .tdi_o(tdi_i),
		.tdo_i(tdo_o));

	// Clock, hang guard and monitor byte collector; the collector looks
	// at the fall, where the handshake of the next rise already stands
	always #5 clk_i = ~clk_i;
	always @(negedge clk_i) begin
		cycles++;
		if (mon_valid_o === 1'b1 && mon_ready_i)
			got.push_back(mon_data_o);
		if (cycles == 60000) begin
			mismatches++;
			tally_and_finish();
		end
	end

	// ------------------------------------------------------------------
	// Shared helpers
	// ------------------------------------------------------------------
	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask : tick

	task automatic check(input string what, input logic [63:0] seen, exp);
		compares++;
		if (seen !== exp) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic tally_and_finish();
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : tally_and_finish

	// ------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------
	// Identification read straight after reset, echoed on the stream
	task automatic t_idcode();
		logic [CHAIN_LEN-1:0] q;
		got.delete();
		host.reset_tap(5);
		host.scan(1'b0, '0, ID_LEN, q);
		check("idcode", q[31:0], IDCODE_DEFAULT);
		tick(20);
		check("mon count", got.size(), 4);
		for (int i = 0; i < 4; i++) begin
			check("mon byte", got[i], IDCODE_DEFAULT[8*i +: 8]);
		end
		$display("test idcode done");
	endtask : t_idcode

	// One-bit paths; an unused code must act as bypass
	task automatic t_bypass();
		instr_t codes[3] = '{INSTR_BYPASS, INSTR_HIGHZ, 4'h7};
		logic [CHAIN_LEN-1:0] q;
		foreach (codes[k]) begin
			host.scan(1'b1, CHAIN_LEN'(codes[k]), IR_LEN, q);
			check("ir capture", q[IR_LEN-1:0], IR_CAPTURE);
			host.scan(1'b0, CHAIN_LEN'(8'h96), 8, q);
			check("bypass", q[7:0], 8'h2c);
			tick(6);
			check("pad oe", pad_oe_o,
				codes[k] == INSTR_HIGHZ ? '0 : core_oe_i);
		end
		$display("test bypass done");
	endtask : t_bypass

	// Full chain sample with a stalled stream, then drive the pads
	task automatic t_extest();
		logic [CHAIN_LEN-1:0] d, q;
		d = '0;
		d[IO_BASE + IO_OUT_POS] = 1'b1;
		d[IO_BASE + IO_OE_POS] = 1'b1;
		d[IO_BASE + 6 + IO_OE_POS] = 1'b1;
		tick(1);
		mon_ready_i = 1'b0;
		got.delete();
		host.scan(1'b1, CHAIN_LEN'(INSTR_SAMPLE), IR_LEN, q);
		host.scan(1'b0, d, CHAIN_LEN, q);
		check("ded cap", q[3:0], ded_in_i);
		check("pin cap", q[IO_BASE+3 +: 3], 3'b110);
		check("mc cap", q[MC_BASE +: 8], mc_state_i[7:0]);
		check("overrun", mon_overrun_o, 1'b1);
		tick(1);
		mon_ready_i = 1'b1;
		tick(40);
		check("drained", got.size() inside {16, 17}, 1'b1);
		check("first byte", got[0], 8'h6a);
		host.scan(1'b1, CHAIN_LEN'(INSTR_EXTEST), IR_LEN, q);
		tick(6);
		check("ext out", pad_out_o, 64'h1);
		check("ext oe", pad_oe_o, 64'h5);
		host.scan(1'b1, CHAIN_LEN'(INSTR_BYPASS), IR_LEN, q);
		$display("test extest done");
	endtask : t_extest

	// Port off: pins go to the user, then a mid-run reset
	task automatic t_disable();
		tick(1);
		jtag_en_i = 1'b0;
		user_tdo_oe_i = 1'b1;
		user_tdo_i = 1'b1;
		core_out_i = 64'h3c;
		tick(6);
		check("user tdo", {user_tdo_oe_o, user_tdo_o}, 2'b11);
		check("user pins", user_pin_in_o, {tdi_i, tms_i, tck_i});
		check("pulls off", {pullup_tms_en_o, pullup_tdi_en_o}, 0);
		check("pads", pad_out_o, core_out_i);
		check("ded in", core_ded_in_o, ded_in_i);
		host.reset_tap(2);
		check("tdo off", tdo_oe_o, 1'b0);
		tick(1);
		jtag_en_i = 1'b1;
		user_tdo_oe_i = 1'b0;
		pullup_tdi_sel_i = 1'b0;
		tick(6);
		check("pulls on", {pullup_tms_en_o, pullup_tdi_en_o}, 2);
		reset_i = 1'b1;
		tick(2);
		reset_i = 1'b0;
		tick(4);
		$display("test disable done");
		t_idcode();
	endtask : t_disable

	// Main sequence
	initial begin
		repeat (6) @(posedge clk_i);
		#1 reset_i = 1'b0;
		tick(4);
		t_idcode();
		t_bypass();
		t_extest();
		t_disable();
		tally_and_finish();
	end

endmodule : boundary_scan_test_port_tb

`default_nettype wire
